// ==== core/prm_pkg.sv ====
// Package of constants and types for the pipelined read master
package prm_pkg;
    // ------------------------------------------------------------
    // Widths and word geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned LEN_W       = 32;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned WORD_BYTES  = 4;
    localparam int unsigned BE_W        = DATA_W / 8;
    // ------------------------------------------------------------
    // Buffer geometry, reset values and full byteenable
    // ------------------------------------------------------------
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [LEN_W-1:0]  LEN_RST  = 32'h0000_0000;
    localparam logic [BE_W-1:0]   BE_FULL  = 4'hf;
    // Run state
    typedef enum logic [0:0] {PRM_IDLE, PRM_RUN} prm_state_t;
endpackage

// ==== core/prm_fifo.sv ====
// Synchronous FIFO holding returned read words
`timescale 1ns/10ps
module prm_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned CNT_W = $clog2(DEPTH+1)
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic             wr_valid,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_ready,
    output logic                  rd_valid,
    output logic      [WIDTH-1:0] rd_data,
    output logic      [CNT_W-1:0] level
);
    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Refuse depths the wrapping pointers cannot serve
    if (DEPTH < 2 || (DEPTH & (DEPTH-1)) != 0) begin : g_bad_depth
        $error("prm_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             push, pop;

    // ------------------------------------------------------------
    // Pointer and occupancy
    // ------------------------------------------------------------
    // Pushes beyond full are dropped; the master's tracker prevents them
    always_comb begin
        push  = wr_valid && (cnt_q != CNT_W'(DEPTH));
        pop   = rd_ready && (cnt_q != '0);
        wp_d  = push ? PTR_W'(wp_q + 1'b1) : wp_q;
        rp_d  = pop  ? PTR_W'(rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = CNT_W'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = CNT_W'(cnt_q - 1'b1);
        end
    end

    // Register pointers and level
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage array, no reset
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp_q] <= wr_data;
        end
    end

    assign rd_valid = (cnt_q != '0);
    assign rd_data  = mem[rp_q];
    assign level    = cnt_q;
endmodule

// ==== core/prm_master.sv ====
// Pipelined memory-mapped read master with return FIFO and read tracker
//
// Behaviour
// - Launch captures start address and byte count
// - Reads issue back to back after capture
// - Each posted read adds four, subtracts four
// - Read held high while length remains, unless stored words plus outstanding reads reach threshold
// - Address/length update only on posted, nonzero
// - Posted means read high, waitrequest low
// - Waitrequest high holds address, byteenable, read
// - Readdatavalid writes readdata into the FIFO
// - Outstanding counter up/down/hold on post, return
// - No post beyond free FIFO space
// - Done only when length and outstanding zero
// - Full-word aligned sequential reads only
`timescale 1ns/10ps
module prm_master
    import prm_pkg::*;
#(
    parameter int unsigned DEPTH     = prm_pkg::FIFO_DEPTH,
    parameter int unsigned THRESHOLD = prm_pkg::FIFO_DEPTH,
    parameter int unsigned CNT_W     = $clog2(DEPTH+1)
) (
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    // Launch side
    input  wire logic                      go,
    input  wire logic [prm_pkg::ADDR_W-1:0] start_address,
    input  wire logic [prm_pkg::LEN_W-1:0]  transfer_length,
    output logic                           done,
    output logic                           busy,
    // Memory-mapped master side
    output logic      [prm_pkg::ADDR_W-1:0] address,
    output logic      [prm_pkg::BE_W-1:0]   byteenable,
    output logic                           read,
    input  wire logic                      waitrequest,
    input  wire logic [prm_pkg::DATA_W-1:0] readdata,
    input  wire logic                      readdatavalid,
    // Drain side of the return FIFO
    output logic                           user_valid,
    output logic      [prm_pkg::DATA_W-1:0] user_data,
    input  wire logic                      user_ready,
    output logic      [CNT_W-1:0]          fifo_level
);
    import prm_pkg::*;

    // Refuse a threshold the tracker cannot serve
    if (THRESHOLD < 1 || THRESHOLD > DEPTH) begin : g_bad_threshold
        $error("prm_master threshold must lie in 1..DEPTH");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    prm_state_t        state_q, state_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [LEN_W-1:0]  len_q, len_d;
    logic [CNT_W-1:0]  outst_q, outst_d;
    logic              done_q, done_d;
    logic              posted;
    logic              room;
    logic [CNT_W:0]    used;

    // ------------------------------------------------------------
    // Request qualification
    // ------------------------------------------------------------
    // Outstanding reads plus stored words must leave room for one more
    always_comb begin
        used   = (CNT_W+1)'(fifo_level) + (CNT_W+1)'(outst_q);
        room   = (used < (CNT_W+1)'(THRESHOLD));
        read   = (state_q == PRM_RUN) && (len_q != '0) && room;
        posted = read && !waitrequest;
    end

    // Next-state computation for run control and tracker
    always_comb begin
        state_d = state_q;
        addr_d  = addr_q;
        len_d   = len_q;
        outst_d = outst_q;
        done_d  = done_q;
        // Tracker counts posted reads not yet returned
        if (posted && !readdatavalid) begin
            outst_d = CNT_W'(outst_q + 1'b1);
        end else if (!posted && readdatavalid && outst_q != '0) begin
            outst_d = CNT_W'(outst_q - 1'b1);
        end
        case (state_q)
            PRM_IDLE: begin
                if (go) begin
                    addr_d  = {start_address[ADDR_W-1:2], 2'b00};
                    len_d   = transfer_length;
                    done_d  = 1'b0;
                    state_d = PRM_RUN;
                end
            end
            PRM_RUN: begin
                // Hold while waitrequest is high: posted stays low
                if (posted && len_q != '0) begin
                    addr_d = ADDR_W'(addr_q + WORD_BYTES);
                    len_d  = LEN_W'(len_q - WORD_BYTES);
                end
                if (len_q == '0 && outst_q == '0) begin
                    done_d  = 1'b1;
                    state_d = PRM_IDLE;
                end
            end
            default: begin
                state_d = PRM_IDLE;
            end
        endcase
    end

    // Register run control
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= PRM_IDLE;
            addr_q  <= ADDR_RST;
            len_q   <= LEN_RST;
            outst_q <= '0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q  <= addr_d;
            len_q   <= len_d;
            outst_q <= outst_d;
            done_q  <= done_d;
        end
    end

    assign address    = addr_q;
    assign byteenable = BE_FULL;
    assign done       = done_q;
    assign busy       = (state_q == PRM_RUN);

    // ------------------------------------------------------------
    // Return buffer
    // ------------------------------------------------------------
    // Readdatavalid is the write enable
    prm_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH),
        .CNT_W (CNT_W)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .wr_valid (readdatavalid),
        .wr_data  (readdata),
        .rd_ready (user_ready),
        .rd_valid (user_valid),
        .rd_data  (user_data),
        .level    (fifo_level)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Launch captures the byte count
    property p_capture;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_q == PRM_IDLE && go) |=> (len_q == $past(transfer_length));
    endproperty
    a_capture: assert property (p_capture) else $error("length not captured");

    // Launch captures the base, word aligned
    property p_base;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_q == PRM_IDLE && go) |=>
            (addr_q[1:0] == 2'b00) &&
            (addr_q[ADDR_W-1:2] == $past(start_address[ADDR_W-1:2]));
    endproperty
    a_base: assert property (p_base) else $error("base address not captured");

    property p_step;
        @(posedge ref_clk) disable iff (!arst_n)
        (posted && state_q == PRM_RUN) |=>
            (addr_q == $past(addr_q) + 32'h4) && (len_q == $past(len_q) - 32'h4);
    endproperty
    a_step: assert property (p_step) else $error("address or length step wrong");

    property p_hold;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_q == PRM_RUN && !posted) |=>
            (addr_q == $past(addr_q)) && (len_q == $past(len_q));
    endproperty
    a_hold: assert property (p_hold) else $error("address moved without a post");

    // A stalled read stays up with the same address
    property p_wait;
        @(posedge ref_clk) disable iff (!arst_n)
        (read && waitrequest) |=> read && (address == $past(address));
    endproperty
    a_wait: assert property (p_wait) else $error("read changed under waitrequest");

    property p_room;
        @(posedge ref_clk) disable iff (!arst_n)
        read |-> (32'(fifo_level) + 32'(outst_q) < THRESHOLD);
    endproperty
    a_room: assert property (p_room) else $error("read issued without FIFO room");

    property p_track;
        @(posedge ref_clk) disable iff (!arst_n)
        (posted && !readdatavalid) |=> (outst_q == $past(outst_q) + 1'b1);
    endproperty
    a_track: assert property (p_track) else $error("tracker missed a posted read");

    // A return with no post takes one off the tracker
    property p_untrack;
        @(posedge ref_clk) disable iff (!arst_n)
        (!posted && readdatavalid && outst_q != '0) |=> (outst_q == $past(outst_q) - 1'b1);
    endproperty
    a_untrack: assert property (p_untrack) else $error("tracker missed a return");

    property p_done;
        @(posedge ref_clk) disable iff (!arst_n)
        $rose(done) |-> ($past(len_q) == '0) && ($past(outst_q) == '0);
    endproperty
    a_done: assert property (p_done) else $error("done raised with reads pending");

    property p_launch;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_q == PRM_IDLE && go) |=> !done && busy;
    endproperty
    a_launch: assert property (p_launch) else $error("done not cleared by launch");

    property p_start;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_q == PRM_IDLE && go && transfer_length != '0 && fifo_level == '0
            && outst_q == '0) |=> read;
    endproperty
    a_start: assert property (p_start) else $error("read did not start");
endmodule

// ==== tb/prm_slave_model.sv ====
// Behavioural pipelined read slave wired straight to the master
`timescale 1ns/10ps
module prm_slave_model (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        np,
    input  wire logic        slow,
    input  wire logic [3:0]  rnd,
    input  wire logic [31:0] address,
    input  wire logic        read,
    output logic             waitrequest,
    output logic [31:0]      readdata,
    output logic             readdatavalid
);
    logic [31:0] pend[$];

    // Queue posted reads, return them in order, stall at random or, with np set, while reads pend
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend.delete();
            waitrequest   <= 1'b0;
            readdatavalid <= 1'b0;
            readdata      <= 32'h0;
        end else begin
            readdatavalid <= 1'b0;
            readdata      <= ~readdata; // Idle data never looks valid
            if (pend.size() != 0 && (slow ? &rnd[3:2] : |rnd[3:2])) begin
                readdatavalid <= 1'b1;
                readdata      <= pend.pop_front() ^ 32'h3c3c_a5a5;
            end
            if (read && !waitrequest)
                pend.push_back(address);
            if (np)
                waitrequest <= (pend.size() != 0);
            else
                waitrequest <= slow ? (rnd[1:0] != 2'h0) : (rnd[1:0] == 2'h0);
        end
    end
endmodule

// ==== tb/pipelined_read_master_bench.sv ====
// Self-checking bench for the pipelined read master
`timescale 1ns/10ps
module pipelined_read_master_bench;
    import prm_pkg::*;
    localparam int THR = 6;
    logic        ref_clk, arst_n, go, done, busy, read, waitrequest, readdatavalid;
    logic        user_valid, user_ready, np, slow, stall, hold_q;
    logic [31:0] start_address, transfer_length, address, readdata, user_data, addr_q;
    logic [31:0] base, rem;
    logic [3:0]  byteenable, fifo_level, rnd;
    int          errors, compares, posts, rets, drained, rc, rc0, cyc, seed;

    prm_master #(.DEPTH(8), .THRESHOLD(THR)) u_prm_master (
        .ref_clk(ref_clk), .arst_n(arst_n), .go(go), .start_address(start_address),
        .transfer_length(transfer_length), .done(done), .busy(busy), .address(address),
        .byteenable(byteenable), .read(read), .waitrequest(waitrequest),
        .readdata(readdata), .readdatavalid(readdatavalid), .user_valid(user_valid),
        .user_data(user_data), .user_ready(user_ready), .fifo_level(fifo_level));

    prm_slave_model u_prm_slave_model (
        .ref_clk(ref_clk), .arst_n(arst_n), .np(np), .slow(slow), .rnd(rnd),
        .address(address), .read(read), .waitrequest(waitrequest),
        .readdata(readdata), .readdatavalid(readdatavalid));

    // ----------------------------------------------------------------
    // Clock, random drivers, check and verdict helpers
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) begin
        rnd        <= 4'($random(seed));
        user_ready <= (stall && rc - rc0 < 30) ? 1'b0 : 1'($random(seed));
        rc         <= rc + 1;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Byte address of word i of the current run
    function automatic logic [31:0] word_addr(input int i);
        return base + 32'(4 * i);
    endfunction

    task give_verdict;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Bus and drain monitor
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            give_verdict;
        end
        if (!arst_n)
            hold_q = 1'b0;
        else begin
            if (busy === 1'b1)
                check(read, rem != 0 && fifo_level + posts - rets < THR);
            else
                check(read, 1'b0);
            check(32'(fifo_level), rets - drained);
            check(user_valid, rets != drained);
            if (hold_q) begin
                check(read, 1'b1);
                check(address, addr_q);
            end
            if (read === 1'b1 && waitrequest === 1'b0) begin
                check(address, word_addr(posts));
                check(byteenable, 4'hf);
                posts++;
                rem = rem - 4;
            end
            hold_q = read && waitrequest;
            addr_q = address;
            if (readdatavalid) rets++;
            if (user_valid === 1'b1 && user_ready) begin
                check(user_data, word_addr(drained) ^ 32'h3c3c_a5a5);
                drained++;
            end
            if (done === 1'b1 && !go) begin
                check(rets, posts);
                check(rem, 32'h0);
            end
        end
    end

    // One run: launch, optional refused relaunch or abort, then drain
    task automatic run(input logic [31:0] b, n, input logic p, s, h, ab);
        int k;
        base = b & 32'hffff_fffc;
        rem = n;
        posts = 0; rets = 0; drained = 0;
        np = p; slow = s; stall = h; rc0 = rc;
        start_address = b; transfer_length = n; go = 1'b1;
        @(negedge ref_clk);
        start_address = $random(seed);
        transfer_length = 32'h40;
        check(busy, 1'b1);
        check(done, 1'b0);
        for (k = 0; done !== 1'b1 && k < 3000; k++) begin
            go = (n >= 40 && k == 3); // Ignored while busy
            if (ab && k == 8) begin
                arst_n = 1'b0;
                @(negedge ref_clk);
                check(32'({read, busy, done, fifo_level}), 32'h0);
                arst_n = 1'b1;
                return;
            end
            @(negedge ref_clk);
        end
        for (k = 0; drained < n / 4 && k < 3000; k++) @(negedge ref_clk);
        check(busy, 1'b0);
        check(posts * 4, n);
        check(drained, n / 4);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 56211; errors = 0; compares = 0; cyc = 0; rc = 0; rc0 = 0; hold_q = 0;
        go = 0; np = 0; slow = 0; stall = 0; rnd = 0; user_ready = 0; arst_n = 0;
        start_address = 0; transfer_length = 0; base = 0; rem = 0;
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        run(32'h0000_1000, 32'h0, 0, 0, 0, 0);
        run(32'h0000_2003, 32'h4, 0, 0, 0, 0);
        run(32'h0000_3000, 32'h40, 0, 1, 1, 0);
        run(32'h0000_4000, 32'h14, 1, 0, 0, 0);
        run(32'h0000_5000, 32'h30, 0, 1, 0, 1);
        repeat (10) run($random(seed), ({$random(seed)} % 12) * 4 + 4, 0,
                        1'($random(seed)), 1'($random(seed)), 0);
        give_verdict;
    end
endmodule
